// [design/rps_pkg.sv]
// Package: constants for the reset and clock sequencer
package rps_pkg;
  // ****************************************
  // Timing counts in osc_clock cycles
  // ****************************************
  localparam int unsigned PLL_LOCK_CYCLES = 131072;
  localparam int unsigned WD_PULSE_CYCLES = 512;
  localparam int unsigned BUS_DELAY_CYCLES = 32;
  localparam int unsigned BOOT_SAMPLE_CYCLES = 200;
  localparam int CNT_W = 18;
  localparam logic [CNT_W-1:0] PLL_LOCK_CNT = CNT_W'(PLL_LOCK_CYCLES - 1);
  localparam logic [CNT_W-1:0] WD_PULSE_CNT = CNT_W'(WD_PULSE_CYCLES - 1);
  localparam logic [CNT_W-1:0] BUS_DELAY_CNT = CNT_W'(BUS_DELAY_CYCLES - 1);
  localparam logic [CNT_W-1:0] BOOT_SAMPLE_CNT = CNT_W'(BOOT_SAMPLE_CYCLES - 1);

  // ****************************************
  // PLL ratio and divider encodings
  // ****************************************
  localparam logic [15:0] PLL_RATIO_RESET = 16'h0000;
  localparam logic [15:0] PLL_RATIO_X2 = 16'h0004;
  localparam logic [15:0] PLL_RATIO_X4 = 16'h0008;
  // System clock select: value of divider code
  localparam logic [2:0] SYS_DIV4 = 3'h0;
  localparam logic [2:0] SYS_DIV2 = 3'h1;
  localparam logic [2:0] SYS_X2 = 3'h2;
  localparam logic [2:0] SYS_X4 = 3'h3;
  localparam logic XIF_TIMING_RESET = 1'h1;
  localparam logic XIF_OUTDIV_RESET = 1'h1;
  localparam int BOOT_W = 4;

  typedef enum logic [2:0] {
    RPS_IN_RESET = 3'b000,
    RPS_WD_PULSE = 3'b001,
    RPS_BUS_WAIT = 3'b010,
    RPS_BOOT_WAIT = 3'b011,
    RPS_RUN = 3'b100
  } rps_state_t;
endpackage

// [design/rps_reset_sync.sv]
// Two-stage synchroniser for the external reset pin
`timescale 1ns/10ps
module rps_reset_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1;
  logic stage2;
  logic next_stage1;
  logic next_stage2;

  always_comb begin
    next_stage1 = asyncIn;
    next_stage2 = stage1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign syncOut = stage2;
endmodule

// [design/rps_sequencer.sv]
// Reset qualification, boot sampling and system clock ratio control
`timescale 1ns/10ps
module rps_sequencer
  import rps_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic device_reset_n,
  input wire logic watchdogTrip,
  input wire logic [BOOT_W-1:0] bootModePins,
  input wire logic ratioWrite,
  input wire logic [15:0] ratioData,
  input wire logic sysDivTwoReq,
  input wire logic xifWrite,
  input wire logic xifTimingIn,
  input wire logic xifOutDivIn,
  output logic coreReset,
  output logic watchdogResetOut,
  output logic busValid,
  output logic bootValid,
  output logic [BOOT_W-1:0] bootMode,
  output logic [15:0] pll_ratio_reg,
  output logic pllLocking,
  output logic [2:0] sysClockSel,
  output logic xif_timing_clock_div,
  output logic xif_output_div_sel,
  output logic [4:0] extClockDivide
);
  // ****************************************
  // Reset pin synchronisation
  // ****************************************
  logic resetPinSync;

  // Clock arrives already selected from crystal or external input
  rps_reset_sync rps_reset_sync_i (
    .clk(clk),
    .srst(srst),
    .asyncIn(device_reset_n),
    .syncOut(resetPinSync)
  );

  // ****************************************
  // Reset sequence state
  // ****************************************
  rps_state_t state;
  rps_state_t next_state;
  logic [CNT_W-1:0] seqCnt;
  logic [CNT_W-1:0] next_seqCnt;
  logic next_coreReset;
  logic next_watchdogResetOut;
  logic next_busValid;
  logic next_bootValid;
  logic [BOOT_W-1:0] next_bootMode;

  always_comb begin
    next_state = state;
    next_seqCnt = seqCnt;
    next_bootValid = bootValid;
    next_bootMode = bootMode;
    case (state)
      RPS_IN_RESET: begin
        next_seqCnt = '0;
        next_bootValid = 1'b0;
        // The partner guarantees the minimum low time, so release is taken at once
        if (resetPinSync) begin
          next_state = RPS_BUS_WAIT;
        end
      end
      RPS_WD_PULSE: begin
        next_seqCnt = seqCnt + CNT_W'(1);
        if (seqCnt == WD_PULSE_CNT) begin
          next_state = RPS_BUS_WAIT;
          next_seqCnt = '0;
        end
      end
      RPS_BUS_WAIT: begin
        next_seqCnt = seqCnt + CNT_W'(1);
        if (seqCnt == BUS_DELAY_CNT) begin
          next_state = RPS_BOOT_WAIT;
          next_seqCnt = '0;
        end
      end
      RPS_BOOT_WAIT: begin
        next_seqCnt = seqCnt + CNT_W'(1);
        // Pins are caught late so the hold window covers the sample
        if (seqCnt == BOOT_SAMPLE_CNT) begin
          next_state = RPS_RUN;
          next_bootMode = bootModePins;
          next_bootValid = 1'b1;
          next_seqCnt = '0;
        end
      end
      RPS_RUN: begin
        next_seqCnt = '0;
      end
      default: begin
        next_state = RPS_IN_RESET;
        next_seqCnt = '0;
      end
    endcase
    if (!resetPinSync) begin
      next_state = RPS_IN_RESET;
      next_seqCnt = '0;
    end else if (watchdogTrip && state != RPS_WD_PULSE) begin
      next_state = RPS_WD_PULSE;
      next_seqCnt = '0;
      next_bootValid = 1'b0;
    end
    next_coreReset = (next_state == RPS_IN_RESET) || (next_state == RPS_WD_PULSE);
    next_watchdogResetOut = (next_state == RPS_WD_PULSE);
    next_busValid = (next_state == RPS_BOOT_WAIT) || (next_state == RPS_RUN);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= RPS_IN_RESET;
      seqCnt <= '0;
      coreReset <= 1'b1;
      watchdogResetOut <= 1'b0;
      busValid <= 1'b0;
      bootValid <= 1'b0;
      bootMode <= '0;
    end else begin
      state <= next_state;
      seqCnt <= next_seqCnt;
      coreReset <= next_coreReset;
      watchdogResetOut <= next_watchdogResetOut;
      busValid <= next_busValid;
      bootValid <= next_bootValid;
      bootMode <= next_bootMode;
    end
  end

  // ****************************************
  // System clock ratio and lock timer
  // ****************************************
  logic [CNT_W-1:0] lockCnt;
  logic [CNT_W-1:0] next_lockCnt;
  logic [15:0] next_pll_ratio_reg;
  logic next_pllLocking;
  logic [2:0] next_sysClockSel;
  logic next_xif_timing_clock_div;
  logic next_xif_output_div_sel;
  logic [4:0] next_extClockDivide;
  logic [4:0] sysDivide;
  logic [2:0] xifShift;
  logic holdControls;

  // Only ratio codes that map to a multiplier are decoded; others fall to osc/2
  function automatic logic [2:0] rps_decode(input logic [15:0] ratio);
    logic [2:0] sel;
    sel = SYS_DIV2;
    if (ratio == PLL_RATIO_X2) begin
      sel = SYS_X2;
    end else if (ratio == PLL_RATIO_X4) begin
      sel = SYS_X4;
    end
    return sel;
  endfunction

  always_comb begin
    holdControls = coreReset && !watchdogResetOut;
    next_lockCnt = lockCnt;
    next_pll_ratio_reg = pll_ratio_reg;
    next_pllLocking = pllLocking;
    next_sysClockSel = sysClockSel;
    next_xif_timing_clock_div = xif_timing_clock_div;
    next_xif_output_div_sel = xif_output_div_sel;
    if (ratioWrite) begin
      next_pll_ratio_reg = ratioData;
      next_pllLocking = 1'b1;
      next_lockCnt = '0;
      next_sysClockSel = SYS_DIV2;
    end else if (pllLocking) begin
      next_lockCnt = lockCnt + CNT_W'(1);
      if (lockCnt == PLL_LOCK_CNT) begin
        next_pllLocking = 1'b0;
        next_sysClockSel = rps_decode(pll_ratio_reg);
      end
    end else if (sysDivTwoReq) begin
      next_sysClockSel = SYS_DIV2;
    end
    if (xifWrite) begin
      next_xif_timing_clock_div = xifTimingIn;
      next_xif_output_div_sel = xifOutDivIn;
    end
    if (holdControls) begin
      next_lockCnt = '0;
      next_pll_ratio_reg = PLL_RATIO_RESET;
      next_pllLocking = 1'b0;
      next_sysClockSel = SYS_DIV4;
      next_xif_timing_clock_div = XIF_TIMING_RESET;
      next_xif_output_div_sel = XIF_OUTDIV_RESET;
    end
    // Divide of osc_clock seen at the output pin; zero means a multiplied clock
    case (next_sysClockSel)
      SYS_DIV4: sysDivide = 5'h04;
      SYS_DIV2: sysDivide = 5'h02;
      default: sysDivide = 5'h00;
    endcase
    xifShift = {1'b0, next_xif_timing_clock_div} + {1'b0, next_xif_output_div_sel} + 3'h0;
    next_extClockDivide = 5'(sysDivide << xifShift);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lockCnt <= '0;
      pll_ratio_reg <= PLL_RATIO_RESET;
      pllLocking <= 1'b0;
      sysClockSel <= SYS_DIV4;
      xif_timing_clock_div <= XIF_TIMING_RESET;
      xif_output_div_sel <= XIF_OUTDIV_RESET;
      extClockDivide <= 5'h10;
    end else begin
      lockCnt <= next_lockCnt;
      pll_ratio_reg <= next_pll_ratio_reg;
      pllLocking <= next_pllLocking;
      sysClockSel <= next_sysClockSel;
      xif_timing_clock_div <= next_xif_timing_clock_div;
      xif_output_div_sel <= next_xif_output_div_sel;
      extClockDivide <= next_extClockDivide;
    end
  end
endmodule

// [testbench/rps_supervisor.sv]
// Reset supervisor and boot-pin model
`timescale 1ns/10ps
module rps_supervisor (
  input wire logic clk,
  input wire logic warmReq,
  input wire logic [3:0] bootVal,
  output logic device_reset_n = 1'h0,
  output logic [3:0] bootModePins = 4'h0
);
  int low = 0;
  int held = 0;
  always @(posedge clk) begin
    low <= warmReq ? 0 : low + (low < 40);
    device_reset_n <= !warmReq && low >= 40;
    held <= device_reset_n ? held + (held < 300) : 0;
    // Pins invert once the hold runs out, so a late sample is caught
    bootModePins <= held < 250 ? bootVal : ~bootVal;
  end
endmodule

// [testbench/rps_seq_monitor.sv]
// Checker for the reset and clock sequencer
`timescale 1ns/10ps
module rps_seq_monitor
  import rps_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic device_reset_n,
  input wire logic watchdogTrip,
  input wire logic ratioWrite,
  input wire logic coreReset,
  input wire logic watchdogResetOut,
  input wire logic busValid,
  input wire logic bootValid,
  input wire logic [15:0] pll_ratio_reg,
  input wire logic pllLocking,
  input wire logic [2:0] sysClockSel,
  input wire logic xif_timing_clock_div,
  input wire logic xif_output_div_sel,
  input wire logic [4:0] extClockDivide
);
  logic [17:0] lockCnt, wdCnt;
  logic [5:0] quiet;
  // A write clears the count, so a restart counts like a fresh lock
  always_ff @(posedge clk) begin
    lockCnt <= (ratioWrite || !pllLocking) ? '0 : lockCnt + 18'h1;
    wdCnt <= watchdogResetOut ? wdCnt + 18'h1 : '0;
    quiet <= coreReset ? '0 : quiet + 6'(quiet != 6'h3F);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_lock_start: assert property (ratioWrite && !coreReset |=> pllLocking && sysClockSel == SYS_DIV2)
    else $error("lock did not start");
  a_lock_length: assert property ($fell(pllLocking) && !coreReset |-> lockCnt == 18'h20000)
    else $error("lock length wrong");
  a_lock_decode: assert property ($fell(pllLocking) && !coreReset |-> sysClockSel ==
    (pll_ratio_reg == PLL_RATIO_X4 ? SYS_X4 : pll_ratio_reg == PLL_RATIO_X2 ? SYS_X2 : SYS_DIV2))
    else $error("ratio decode wrong");
  a_wd_start: assert property (watchdogTrip && device_reset_n && !coreReset |=> watchdogResetOut && coreReset)
    else $error("watchdog pulse missing");
  a_wd_length: assert property ($fell(watchdogResetOut) |-> wdCnt == 18'h200)
    else $error("watchdog pulse length");
  a_bus_delay: assert property ($rose(busValid) |-> quiet inside {[32:34]})
    else $error("bus valid delay");
  a_boot_delay: assert property ($rose(bootValid) |-> $past(busValid, 200) && !$past(busValid, 201))
    else $error("boot sample delay");
  // Sync, state and control registers take four edges before the held values show
  a_pin_hold: assert property (!device_reset_n [*5] |-> sysClockSel == SYS_DIV4 && extClockDivide == 5'h10
    && xif_timing_clock_div && xif_output_div_sel && pll_ratio_reg == PLL_RATIO_RESET)
    else $error("controls not held in reset");
endmodule
bind rps_sequencer rps_seq_monitor rps_seq_monitor_i (.*);

// [testbench/reset_and_pll_clock_sequencer_bench.sv]
// Self-checking bench for the reset and clock sequencer
`timescale 1ns/10ps
module reset_and_pll_clock_sequencer_bench;
  import rps_pkg::*;
  logic clk = '0, srst = '1, watchdogTrip = '0, ratioWrite = '0, sysDivTwoReq = '0;
  logic xifWrite = '0, xifTimingIn = '1, xifOutDivIn = '1, warmReq = '0;
  logic [15:0] ratioData = 16'h0000;
  logic [BOOT_W-1:0] bootVal = 4'hA, bootModePins, bootMode;
  logic device_reset_n, coreReset, watchdogResetOut, busValid, bootValid, pllLocking;
  logic xif_timing_clock_div, xif_output_div_sel;
  logic [15:0] pll_ratio_reg;
  logic [2:0] sysClockSel;
  logic [4:0] extClockDivide;
  int bad_count = 0, compares = 0, n;
  rps_supervisor rps_supervisor_i (.*);
  rps_sequencer rps_sequencer_i (.*);
  initial forever #2.5 clk = ~clk;
  task check(input string what, input logic [17:0] exp, got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task boot_seq(input logic [3:0] exp);
    n = 0;
    while (device_reset_n !== 1'b1) tick(1);
    while (busValid !== 1'b1 && n < 99) begin
      tick(1);
      n++;
    end
    check("bus wait", 1, n inside {[31:36]});
    n = 0;
    while (bootValid !== 1'b1 && n < 999) begin
      tick(1);
      n++;
    end
    check("boot wait", 200, n);
    check("boot mode", exp, bootMode);
  endtask
  task t_power;
    check("sel", SYS_DIV4, sysClockSel);
    check("ext div", 5'h10, extClockDivide);
    check("xif", 2'h3, {xif_timing_clock_div, xif_output_div_sel});
    boot_seq(4'hA);
    $display("end power");
  endtask
  task t_div;
    @(posedge clk) sysDivTwoReq <= 1;
    @(posedge clk) sysDivTwoReq <= 0;
    tick(1);
    check("sel", SYS_DIV2, sysClockSel);
    check("ext div", 5'h08, extClockDivide);
    @(posedge clk) xifTimingIn <= 0;
    xifWrite <= 1;
    @(posedge clk) xifWrite <= 0;
    tick(1);
    check("ext div", 5'h04, extClockDivide);
    $display("end divide");
  endtask
  task t_wd;
    @(posedge clk) watchdogTrip <= 1;
    @(posedge clk) watchdogTrip <= 0;
    #1;
    n = 0;
    while (watchdogResetOut === 1'b1 && n < 999) begin
      tick(1);
      n++;
    end
    check("wd pulse", 512, n);
    check("sel", SYS_DIV2, sysClockSel);
    boot_seq(4'h5);
    $display("end watchdog");
  endtask
  task t_lock;
    @(posedge clk) ratioWrite <= 1;
    ratioData <= PLL_RATIO_X2;
    @(posedge clk) ratioWrite <= 0;
    tick(9);
    @(posedge clk) ratioWrite <= 1;
    ratioData <= PLL_RATIO_X4;
    @(posedge clk) ratioWrite <= 0;
    #1;
    check("locking", 1, pllLocking);
    check("sel", SYS_DIV2, sysClockSel);
    n = 0;
    while (pllLocking === 1'b1 && n < 140000) begin
      tick(1);
      n++;
    end
    check("lock len", 131072, n);
    check("sel", SYS_X4, sysClockSel);
    check("ratio", PLL_RATIO_X4, pll_ratio_reg);
    check("ext div", 5'h00, extClockDivide);
    $display("end lock");
  endtask
  task t_warm;
    bootVal = 4'h6;
    @(posedge clk) warmReq <= 1;
    @(posedge clk) warmReq <= 0;
    tick(10);
    check("sel", SYS_DIV4, sysClockSel);
    check("ext div", 5'h10, extClockDivide);
    check("core reset", 1, coreReset);
    boot_seq(4'h6);
    $display("end warm");
  endtask
  task finish_test;
    $display("compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    srst <= 0;
    tick(1);
    t_power;
    t_div;
    t_wd;
    t_lock;
    t_warm;
    finish_test;
  end
  initial begin
    #800000;
    bad_count++;
    finish_test;
  end
endmodule
